// File: clk_cfg_defines.svh
// Purpose: Register indices, reset values and constants of the clock configuration block
// Assumes: Byte address of each register is four times its index
// Notes:   Definitions only
`ifndef CLK_CFG_DEFINES_SVH
`define CLK_CFG_DEFINES_SVH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define IDX_DIV_EN    8'h45
`define IDX_GP_SRC    8'h46
`define IDX_GP_DIV    8'h47
`define IDX_CONV      8'h49
`define IDX_STATUS    8'h4A

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define RST_DIV_EN    8'h00
`define RST_GP_SRC    8'h00
`define RST_GP_DIV    8'h01
`define RST_CONV      8'h00
`define MASK_DIV_EN   8'h1F
`define MASK_GP_SRC   8'h07
`define MASK_GP_DIV   8'hFF
`define MASK_CONV     8'hFF

// ------------------------------------------------------------
// Divide constants
// ------------------------------------------------------------
`define GP_DIV_FULL   8'h80
`define CONV_RATIO_1  4'h1
`define NUM_FAST_DIV  5
`define NUM_GP_SRC    6

`endif

// File: clk_cfg_pkg.sv
// Purpose: Types of the clock configuration block
// Assumes: Field order of each struct matches the register bit layout
// Notes:   Shared by all design files
package clk_cfg_pkg;

  typedef struct packed {
    logic [2:0] reserved;
    logic       modulator_divider_enable;
    logic       primary_bitclk_divider_enable;
    logic       secondary_bitclk_divider_enable;
    logic       primary_frame_divider_enable;
    logic       secondary_frame_divider_enable;
  } divider_enable_t;

  typedef enum logic [2:0] {
    SRC_PLL          = 3'h0,
    SRC_PRIMARY_BCK  = 3'h1,
    SRC_SECOND_BCK   = 3'h2,
    SRC_CTRL_PORT    = 3'h3,
    SRC_OSCILLATOR   = 3'h4,
    SRC_DSP          = 3'h5,
    SRC_RESERVED_6   = 3'h6,
    SRC_RESERVED_7   = 3'h7
  } gp_source_t;

  typedef struct packed {
    logic       gp_clock_divider_enable;
    logic [6:0] gp_clock_divide_value;
  } gp_divider_t;

  typedef enum logic [1:0] {
    FREQ_6MHZ   = 2'h0,
    FREQ_3MHZ   = 2'h1,
    FREQ_1P5MHZ = 2'h2,
    FREQ_12MHZ  = 2'h3
  } conv_freq_t;

  typedef struct packed {
    conv_freq_t converter_clock_freq_mode;
    logic       converter_source_auto_off;
    logic       converter_source_manual_pick;
    logic       converter_enable_auto_off;
    logic       converter_divider_manual_on;
    logic [1:0] converter_divider_manual_value;
  } converter_setup_t;

  typedef struct packed {
    logic       conv_on;
    logic       conv_osc;
    logic       gp_src_valid;
    logic [4:0] fast_level;
  } status_t;

  typedef struct packed {
    logic tick;
    logic level;
  } div_out_t;

endpackage

// File: tick_divider.sv
// Purpose: Divides a stream of source ticks by a ratio
// Assumes: ratio is at least 1
// Notes:   Held cleared while disabled
module tick_divider #(
  parameter int W = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                enable,
  input  wire logic                src_tick,
  input  wire logic [W-1:0]        ratio,
  output clk_cfg_pkg::div_out_t    out
);
  import clk_cfg_pkg::*;

  logic [W-1:0] count_reg;
  div_out_t     out_reg;
  wire          wrap = (count_reg == ratio - W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      out_reg   <= '0;
    end else if (!enable) begin
      count_reg <= '0;
      out_reg   <= '0;
    end else begin
      out_reg.tick <= src_tick && wrap;
      if (src_tick) count_reg <= wrap ? '0 : count_reg + W'(1);
      if (src_tick && wrap) out_reg.level <= !out_reg.level;
    end
  end

  assign out = out_reg;

  a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> (!out.tick && !out.level && count_reg == '0))
    else $error("divider not held while disabled");

endmodule // tick_divider

// File: tick_source_mux.sv
// Purpose: Registered selection of one source tick for the clock output
// Assumes: Source ticks are one cycle wide
// Notes:   Reserved codes select nothing
module tick_source_mux #(
  parameter int N = 6
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  clk_cfg_pkg::gp_source_t      sel,
  input  wire logic [N-1:0]            src_ticks,
  output logic                         sel_tick,
  output logic                         sel_valid
);
  import clk_cfg_pkg::*;

  // Widened so reserved codes never index past the tick lines
  wire [7:0] ticks_wide = 8'(src_ticks);
  wire       valid_code = (int'(sel) < N);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_tick  <= 1'b0;
      sel_valid <= 1'b0;
    end else begin
      sel_tick  <= valid_code && ticks_wide[sel];
      sel_valid <= valid_code;
    end
  end

endmodule // tick_source_mux

// File: clk_cfg.sv
// Purpose: APB programmed enables and dividers for internal audio clocks
// Assumes: Source clocks arrive as one-cycle ticks on pclk
// Notes:   Zero wait state slave; unmapped addresses answer pslverr
`include "clk_cfg_defines.svh"

// Functional notes
// - Enable bit gates modulator clock divider
// - Enable bit gates primary bit-clock divider
// - Enable bit gates secondary bit-clock divider
// - Enable bit gates primary frame divider
// - Enable bit gates secondary frame divider
// - Source code picks clock output source
// - Enable bit gates clock output divider
// - Divide by value; zero means 128
// - Frequency mode field selects converter rate
// - Source auto mode while bit clear
// - Manual source: audio or oscillator
// - Divider auto enabled while bit clear
// - Manual enable used outside auto enable
// - Manual divide 1,2,4,8 outside source auto mode
module clk_cfg #(
  parameter int ADDR_W  = 12,
  parameter int RATIO_W = 10
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic [ADDR_W-1:0]                   paddr,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic [31:0]                              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [`NUM_FAST_DIV-1:0]            fast_src_tick,
  input  wire logic [`NUM_FAST_DIV-1:0][RATIO_W-1:0] fast_ratio,
  output clk_cfg_pkg::div_out_t [`NUM_FAST_DIV-1:0] fast_out,
  input  wire logic [`NUM_GP_SRC-1:0]              gp_src_tick,
  output clk_cfg_pkg::div_out_t                    gp_out,
  input  wire logic                                audio_tick,
  input  wire logic                                osc_tick,
  input  wire logic                                auto_pick_osc,
  input  wire logic                                auto_enable,
  input  wire logic [1:0]                          auto_div_code,
  output clk_cfg_pkg::div_out_t                    conv_out,
  output clk_cfg_pkg::conv_freq_t                  conv_freq_mode,
  output logic                                     conv_src_osc,
  output logic                                     conv_on
);
  import clk_cfg_pkg::*;

  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] A_DIV_EN = ADDR_W'(`IDX_DIV_EN * 4);
  localparam logic [ADDR_W-1:0] A_GP_SRC = ADDR_W'(`IDX_GP_SRC * 4);
  localparam logic [ADDR_W-1:0] A_GP_DIV = ADDR_W'(`IDX_GP_DIV * 4);
  localparam logic [ADDR_W-1:0] A_CONV   = ADDR_W'(`IDX_CONV * 4);
  localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(`IDX_STATUS * 4);

  // ------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------
  logic [REG_W-1:0] div_en_reg;
  logic [REG_W-1:0] gp_src_reg;
  logic [REG_W-1:0] gp_div_reg;
  logic [REG_W-1:0] conv_reg;
  logic [31:0]      prdata_reg;
  logic             conv_src_osc_reg;
  logic             conv_on_reg;

  wire hit_div_en = (paddr == A_DIV_EN);
  wire hit_gp_src = (paddr == A_GP_SRC);
  wire hit_gp_div = (paddr == A_GP_DIV);
  wire hit_conv   = (paddr == A_CONV);
  wire hit_status = (paddr == A_STATUS);
  wire hit_any    = hit_div_en | hit_gp_src | hit_gp_div | hit_conv | hit_status;
  wire setup_ph   = psel && !penable;
  wire access_ph  = psel && penable;
  wire wr_lane0   = access_ph && pwrite && pstrb[0];
  wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];

  wire wr_div_en = wr_lane0 && hit_div_en;
  wire wr_gp_src = wr_lane0 && hit_gp_src;
  wire wr_gp_div = wr_lane0 && hit_gp_div;
  wire wr_conv   = wr_lane0 && hit_conv;

  // Reserved bits stay zero whatever is written
  wire [REG_W-1:0] div_en_next = wbyte & `MASK_DIV_EN;
  wire [REG_W-1:0] gp_src_next = wbyte & `MASK_GP_SRC;
  wire [REG_W-1:0] gp_div_next = wbyte & `MASK_GP_DIV;
  wire [REG_W-1:0] conv_next   = wbyte & `MASK_CONV;

  // ------------------------------------------------------------
  // Field views
  // ------------------------------------------------------------
  divider_enable_t  den;
  gp_divider_t      gdv;
  converter_setup_t cset;
  gp_source_t       gp_sel;
  status_t          stat;
  logic [`NUM_FAST_DIV-1:0] fast_en;
  logic [`NUM_FAST_DIV-1:0] fast_level;
  logic             gp_sel_tick;
  logic             gp_sel_valid;

  assign den    = divider_enable_t'(div_en_reg);
  assign gdv    = gp_divider_t'(gp_div_reg);
  assign cset   = converter_setup_t'(conv_reg);
  assign gp_sel = gp_source_t'(gp_src_reg[2:0]);

  assign stat.conv_on      = conv_on_reg;
  assign stat.conv_osc     = conv_src_osc_reg;
  assign stat.gp_src_valid = gp_sel_valid;
  assign stat.fast_level   = fast_level;

  wire [REG_W-1:0] rd_mux =
    hit_div_en ? div_en_reg :
    hit_gp_src ? gp_src_reg :
    hit_gp_div ? gp_div_reg :
    hit_conv   ? conv_reg   :
    hit_status ? REG_W'(stat) : '0;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_en_reg <= `RST_DIV_EN;
      gp_src_reg <= `RST_GP_SRC;
      gp_div_reg <= `RST_GP_DIV;
      conv_reg   <= `RST_CONV;
    end else begin
      if (wr_div_en) div_en_reg <= div_en_next;
      if (wr_gp_src) gp_src_reg <= gp_src_next;
      if (wr_gp_div) gp_div_reg <= gp_div_next;
      if (wr_conv) conv_reg <= conv_next;
    end
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= 32'(rd_mux);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = access_ph && !hit_any;

  // ------------------------------------------------------------
  // Serial port and modulator dividers
  // ------------------------------------------------------------
  wire mod_en = den.modulator_divider_enable;
  wire pbk_en = den.primary_bitclk_divider_enable;
  wire sbk_en = den.secondary_bitclk_divider_enable;
  wire pfr_en = den.primary_frame_divider_enable;
  wire sfr_en = den.secondary_frame_divider_enable;

  assign fast_en = {mod_en, pbk_en, sbk_en, pfr_en, sfr_en};

  genvar g;
  generate
    for (g = 0; g < `NUM_FAST_DIV; g++) begin : g_fast
      tick_divider #(.W(RATIO_W)) u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (fast_en[g]),
        .src_tick (fast_src_tick[g]),
        .ratio    (fast_ratio[g]),
        .out      (fast_out[g])
      );
      assign fast_level[g] = fast_out[g].level;
    end
  endgenerate

  // ------------------------------------------------------------
  // General purpose clock output
  // ------------------------------------------------------------
  tick_source_mux #(.N(`NUM_GP_SRC)) u_gp_mux (
    .pclk      (pclk),
    .presetn   (presetn),
    .sel       (gp_sel),
    .src_ticks (gp_src_tick),
    .sel_tick  (gp_sel_tick),
    .sel_valid (gp_sel_valid)
  );

  wire       gp_en    = gdv.gp_clock_divider_enable;
  wire [7:0] gp_ratio = (gdv.gp_clock_divide_value == '0) ? `GP_DIV_FULL
                                                          : {1'b0, gdv.gp_clock_divide_value};

  tick_divider #(.W(REG_W)) u_gp_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (gp_en),
    .src_tick (gp_sel_tick),
    .ratio    (gp_ratio),
    .out      (gp_out)
  );

  // ------------------------------------------------------------
  // Converter clock generator
  // ------------------------------------------------------------
  wire       conv_auto_src = !cset.converter_source_auto_off;
  wire       conv_osc_next = conv_auto_src ? auto_pick_osc
                                           : cset.converter_source_manual_pick;
  wire       conv_auto_en  = !cset.converter_enable_auto_off;
  wire       conv_on_next  = conv_auto_en ? auto_enable
                                          : cset.converter_divider_manual_on;
  wire [1:0] conv_code     = conv_auto_src ? auto_div_code
                                           : cset.converter_divider_manual_value;
  wire [3:0] conv_ratio    = `CONV_RATIO_1 << conv_code;
  wire       conv_tick     = conv_src_osc_reg ? osc_tick : audio_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_src_osc_reg <= 1'b0;
      conv_on_reg      <= 1'b0;
    end else begin
      conv_src_osc_reg <= conv_osc_next;
      conv_on_reg      <= conv_on_next;
    end
  end

  tick_divider #(.W(4)) u_conv_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (conv_on_reg),
    .src_tick (conv_tick),
    .ratio    (conv_ratio),
    .out      (conv_out)
  );

  // Frequency mode is a level to the analog converter; fastest code
  // is only meaningful with the oscillator source, software's duty
  assign conv_freq_mode = cset.converter_clock_freq_mode;
  assign conv_src_osc   = conv_src_osc_reg;
  assign conv_on        = conv_on_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_write(logic hit);
    psel && penable && pwrite && pstrb[0] && hit;
  endsequence

  a_mod_enable: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_div_en) && !wbyte[4] |=> ##1 !fast_out[4].tick && !fast_out[4].level)
    else $error("modulator divider not stopped");

  a_pbk_enable: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_div_en) |=> pbk_en == $past(wbyte[3]))
    else $error("primary bit clock enable wrong");

  a_sbk_enable: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_div_en) |=> sbk_en == $past(wbyte[2]))
    else $error("secondary bit clock enable wrong");

  a_pfr_enable: assert property (@(posedge pclk) disable iff (!presetn)
    !pfr_en [*2] |-> !fast_out[1].tick)
    else $error("primary frame divider ticks while off");

  a_sfr_enable: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_div_en) |=> sfr_en == $past(wbyte[0]) && div_en_reg[7:5] == '0)
    else $error("secondary frame enable wrong");

  a_gp_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (gp_sel == SRC_RESERVED_6 || gp_sel == SRC_RESERVED_7) |=> !gp_sel_tick && !gp_sel_valid)
    else $error("reserved source passed ticks");

  a_gp_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !gp_en [*2] |-> !gp_out.tick && !gp_out.level)
    else $error("clock output active while disabled");

  a_gp_full: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_gp_div) && wbyte[6:0] == '0 |=> gp_ratio == `GP_DIV_FULL)
    else $error("zero divide value not 128");

  a_freq_mode: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_conv) |=> conv_freq_mode == conv_freq_t'($past(wbyte[7:6])))
    else $error("frequency mode not taken");

  a_auto_src: assert property (@(posedge pclk) disable iff (!presetn)
    conv_auto_src && auto_pick_osc |=> conv_src_osc)
    else $error("auto source not followed");

  a_manual_src: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_auto_src [*2] |-> conv_src_osc == $past(cset.converter_source_manual_pick))
    else $error("manual source not followed");

  a_auto_en: assert property (@(posedge pclk) disable iff (!presetn)
    conv_auto_en && !auto_enable |=> !conv_on ##1 !conv_out.tick)
    else $error("auto enable not followed");

  a_manual_en: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_auto_en && cset.converter_divider_manual_on && $stable(conv_reg) |=> conv_on)
    else $error("manual enable ignored");

  a_manual_div: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_auto_src && cset.converter_divider_manual_value == 2'h3 |-> conv_ratio == 4'h8)
    else $error("manual divide of eight wrong");

  sequence s_read_setup(logic hit);
    psel && !penable && !pwrite && hit;
  endsequence

  a_den_readback: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup(hit_div_en) |=> prdata == 32'($past(div_en_reg[4:0])))
    else $error("enable register read wrong");

  a_den_masked: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_div_en) |=> div_en_reg == ($past(wbyte) & `MASK_DIV_EN))
    else $error("enable reserved bits stored");

  a_src_readback: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup(hit_gp_src) |=> prdata == 32'($past(gp_sel)))
    else $error("source register read wrong");

  a_src_masked: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(hit_gp_src) |=> gp_src_reg[7:3] == '0)
    else $error("source reserved bits stored");

  a_gpdiv_readback: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup(hit_gp_div) |=> prdata == 32'($past(gp_div_reg)))
    else $error("output divider read wrong");

  a_conv_readback: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup(hit_conv) |=> prdata == 32'($past(conv_reg)))
    else $error("converter setup read wrong");

  a_gp_tick_cause: assert property (@(posedge pclk) disable iff (!presetn)
    gp_out.tick |-> $past(gp_sel_tick) && $past(gp_en))
    else $error("clock output tick without cause");

  a_pbk_tick_cause: assert property (@(posedge pclk) disable iff (!presetn)
    fast_out[3].tick |-> $past(fast_src_tick[3]) && $past(pbk_en))
    else $error("bit clock tick without cause");

  a_conv_tick_cause: assert property (@(posedge pclk) disable iff (!presetn)
    conv_out.tick |-> $past(conv_tick) && $past(conv_on_reg))
    else $error("converter tick without cause");

endmodule // clk_cfg

// File: clock_divider_output_config_bench.sv
// Purpose: Self-checking bench for the clock configuration block
// Assumes: Zero wait state APB slave, source ticks in the pclk domain
// Notes:   Random rounds from a fixed seed, corner cases in the first rounds
`include "clk_cfg_defines.svh"
module clock_divider_output_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_cfg_pkg::*;

  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        pstrb;
  logic [4:0]        fast_src_tick;
  logic [4:0][9:0]   fast_ratio;
  div_out_t [4:0]    fast_out;
  logic [5:0]        gp_src_tick;
  div_out_t          gp_out, conv_out;
  logic              audio_tick, osc_tick, auto_pick_osc, auto_enable, conv_src_osc, conv_on;
  logic [1:0]        auto_div_code;
  conv_freq_t        conv_freq_mode;
  int                fails, comparisons, cnt_fast[5], cnt_gp, cnt_conv, drv_fast[5], drv_gp[6], drv_audio, drv_osc;

  clk_cfg #(.ADDR_W(12), .RATIO_W(10)) u_clk_cfg (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_src_tick(fast_src_tick), .fast_ratio(fast_ratio), .fast_out(fast_out),
    .gp_src_tick(gp_src_tick), .gp_out(gp_out), .audio_tick(audio_tick), .osc_tick(osc_tick),
    .auto_pick_osc(auto_pick_osc), .auto_enable(auto_enable), .auto_div_code(auto_div_code),
    .conv_out(conv_out), .conv_freq_mode(conv_freq_mode), .conv_src_osc(conv_src_osc), .conv_on(conv_on)
  );

  // ----------------------------------------
  // Clock, output tick counters, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    for (int i = 0; i < 5; i++) cnt_fast[i] += (fast_out[i].tick === 1'b1);
    cnt_gp   += (gp_out.tick === 1'b1);
    cnt_conv += (conv_out.tick === 1'b1);
  end

  // Twelve rounds of about 650 cycles, with ample margin
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test;
  end

  // ----------------------------------------
  // Compare, bus and stimulus tasks
  // ----------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd, input logic [3:0] strb,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    paddr  <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    pstrb  <= strb;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(idx, 1'b1, d, 4'hF, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(idx, 1'b0, 8'h00, 4'hF, rd, err);
    check_val(rd, exp);
    check_val({31'h0, err}, {31'h0, exp_err});
  endtask

  // Dense mode ticks every line on every cycle, the back-to-back corner
  task automatic drive(input int n, input bit dense);
    logic [12:0] v;
    for (int c = 0; c < n; c++) begin
      @(posedge pclk);
      v = dense ? 13'h1FFF : 13'($urandom);
      fast_src_tick <= v[4:0];
      gp_src_tick   <= v[10:5];
      audio_tick    <= v[11];
      osc_tick      <= v[12];
      for (int i = 0; i < 5; i++) drv_fast[i] += v[i];
      for (int i = 0; i < 6; i++) drv_gp[i] += v[5+i];
      drv_audio += v[11];
      drv_osc   += v[12];
    end
    @(posedge pclk);
    fast_src_tick <= 5'h00;
    gp_src_tick   <= 6'h00;
    audio_tick    <= 1'b0;
    osc_tick      <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0]  den, src, gdiv, conv;
    logic [31:0] rd;
    logic        err, on, osc;
    logic [4:0]  lv;
    int          ratio[5], e, code;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {fast_src_tick, gp_src_tick, audio_tick, osc_tick, auto_pick_osc, auto_enable, auto_div_code} = '0;
    fast_ratio = {5{10'h001}};
    void'($urandom(38));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`IDX_DIV_EN, 32'h00, 1'b0);
    rd_chk(`IDX_GP_SRC, 32'h00, 1'b0);
    rd_chk(`IDX_GP_DIV, 32'h01, 1'b0);
    rd_chk(`IDX_CONV, 32'h00, 1'b0);
    rd_chk(`IDX_STATUS, 32'h20, 1'b0);
    // Unmapped place answers with an error and reads zero
    apb(8'h80, 1'b1, 8'hFF, 4'hF, rd, err);
    check_val({31'h0, err}, 32'h1);
    rd_chk(8'h80, 32'h00, 1'b1);
    // Reserved bits stay zero even when software sets them; a write without the lane 0 strobe is ignored
    wr_reg(`IDX_DIV_EN, 8'hFF);
    rd_chk(`IDX_DIV_EN, 32'h1F, 1'b0);
    wr_reg(`IDX_GP_SRC, 8'hFF);
    rd_chk(`IDX_GP_SRC, 32'h07, 1'b0);
    apb(`IDX_GP_DIV, 1'b1, 8'h55, 4'hE, rd, err);
    rd_chk(`IDX_GP_DIV, 32'h01, 1'b0);
    for (int r = 0; r < 12; r++) begin
      den  = 8'($urandom) & `MASK_DIV_EN;
      src  = (r < 8) ? 8'(r) : (8'($urandom) & `MASK_GP_SRC);
      gdiv = 8'($urandom) | ((r < 8) ? 8'h80 : 8'h00);
      if (r == 0) gdiv = 8'h80;
      if (r == 1) gdiv = 8'hFF;
      conv = 8'($urandom);
      conv[5]   = r[0];
      conv[3]   = r[1];
      conv[7:6] = r[2:1];
      if (conv[7:6] == 2'h3) begin
        conv[5] = 1'b1;
        conv[4] = 1'b1;
      end
      for (int i = 0; i < 5; i++) begin
        ratio[i] = 1 + $urandom % 8;
        fast_ratio[i] <= 10'(ratio[i]);
      end
      auto_enable   <= 1'($urandom);
      auto_pick_osc <= 1'($urandom);
      auto_div_code <= 2'($urandom);
      wr_reg(`IDX_DIV_EN, den);
      wr_reg(`IDX_GP_SRC, src);
      wr_reg(`IDX_GP_DIV, gdiv);
      wr_reg(`IDX_CONV, conv);
      rd_chk(`IDX_DIV_EN, {24'h0, den}, 1'b0);
      rd_chk(`IDX_GP_SRC, {24'h0, src}, 1'b0);
      rd_chk(`IDX_GP_DIV, {24'h0, gdiv}, 1'b0);
      rd_chk(`IDX_CONV, {24'h0, conv}, 1'b0);
      repeat (3) @(posedge pclk);
      on   = conv[3] ? conv[2] : auto_enable;
      osc  = conv[5] ? conv[4] : auto_pick_osc;
      code = conv[5] ? int'(conv[1:0]) : int'(auto_div_code);
      check_val({30'h0, conv_freq_mode}, {30'h0, conv[7:6]});
      check_val({31'h0, conv_src_osc}, {31'h0, osc});
      check_val({31'h0, conv_on}, {31'h0, on});
      drive(600, r < 2);
      for (int i = 0; i < 5; i++) begin
        e = den[i] ? drv_fast[i] / ratio[i] : 0;
        check_count(cnt_fast[i], e);
        check_val({30'h0, fast_out[i]}, {31'h0, e[0]});
        lv[i] = e[0];
      end
      e = (src < 6 && gdiv[7]) ? drv_gp[src] / ((gdiv[6:0] == 7'h00) ? 128 : int'(gdiv[6:0])) : 0;
      check_count(cnt_gp, e);
      check_val({30'h0, gp_out}, {31'h0, e[0]});
      e = on ? ((osc ? drv_osc : drv_audio) >> code) : 0;
      check_count(cnt_conv, e);
      check_val({30'h0, conv_out}, {31'h0, e[0]});
      rd_chk(`IDX_STATUS, {24'h0, on, osc, src < 6, lv}, 1'b0);
      wr_reg(`IDX_DIV_EN, 8'h00);
      wr_reg(`IDX_GP_DIV, 8'h01);
      wr_reg(`IDX_CONV, 8'h08);
      repeat (3) @(posedge pclk);
      check_val({17'h0, fast_out, gp_out, conv_out, conv_on}, 32'h0);
      for (int i = 0; i < 5; i++) {cnt_fast[i], drv_fast[i]} = '0;
      for (int i = 0; i < 6; i++) drv_gp[i] = 0;
      {cnt_gp, cnt_conv, drv_audio, drv_osc} = '0;
    end
    finish_test;
  end
endmodule // clock_divider_output_config_bench
